// ==== stm_pkg.sv ====
/*
 Package for the standard timer: register offsets, field positions,
 reset values, mode and tick-source encodings.
 Assumes a byte-wide register port with byte offsets 0 to 6.
*/
package stm_pkg;
  localparam logic [2:0] REG_CTRL0 = 3'h0;
  localparam logic [2:0] REG_CTRL1 = 3'h1;
  localparam logic [2:0] REG_CNT_LO = 3'h2;
  localparam logic [2:0] REG_CNT_HI = 3'h3;
  localparam logic [2:0] REG_CMPA_LO = 3'h4;
  localparam logic [2:0] REG_CMPA_HI = 3'h5;
  localparam logic [2:0] REG_CMPP = 3'h6;
  localparam int CTRL0_HOLD = 7;
  localparam int CTRL0_SRC_LSB = 4;
  localparam int CTRL0_RUN = 3;
  localparam int CTRL1_MODE_LSB = 6;
  localparam int CTRL1_ACT_LSB = 4;
  localparam int CTRL1_INIT = 3;
  localparam int CTRL1_INV = 2;
  localparam int CTRL1_SWAP = 1;
  localparam int CTRL1_CLRSEL = 0;
  localparam logic [7:0] CTRL0_RESET = 8'h00;
  localparam logic [7:0] CTRL0_WMASK = 8'hF8;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] CMP_RESET = 8'h00;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [7:0] SYS_DIV = 8'h04;
  localparam logic [7:0] HS_DIV16 = 8'h10;
  localparam logic [7:0] HS_DIV64 = 8'h40;
  typedef enum logic [1:0] {
    STM_MODE_COMPARE = 2'h0,
    STM_MODE_UNDEF = 2'h1,
    STM_MODE_PWM = 2'h2,
    STM_MODE_TIMER = 2'h3
  } stm_mode_t;
  typedef enum logic [2:0] {
    STM_SRC_SYS4 = 3'h0,
    STM_SRC_SYS = 3'h1,
    STM_SRC_HS16 = 3'h2,
    STM_SRC_HS64 = 3'h3,
    STM_SRC_SUB0 = 3'h4,
    STM_SRC_SUB1 = 3'h5,
    STM_SRC_RSV0 = 3'h6,
    STM_SRC_RSV1 = 3'h7
  } stm_src_t;
endpackage : stm_pkg

// ==== stm_timer.sv ====
/*
 Standard 16-bit timer with comparators A and P and one output pin.
 Assumes high_speed_clock and sub_clock arrive as one-cycle enables from
 the clock system on the same clock; single-pulse shaping lives elsewhere.
*/
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - 16-bit up counter ticks while run, not held
// - Comparator P checks counter bits 15 to 8
// - Comparator A checks all sixteen counter bits
// - Software cannot load; run rise clears counter
// - Overflow or selected match clears, match raises flag
// - Hold freezes counter, resume from held value
// - Tick source select decoding, two codes reserved
// - Run rising edge zeroes counter before counting
// - Run low stops counter, value kept
// - Run rise resets pin to initial level
// - Control zero bits 2 to 0 read zero
// - Mode select: compare, undefined, PWM, timer
// - Compare mode A match drives pin action
// - Requested level equal initial gives no change
// - PWM mode action: inactive, active, PWM, pulse
// - Initial level sets pre-match or active level
// - Invert bit inverts pin except timer mode
// - Swap bit exchanges PWM period and duty roles
// - Clear select picks A match or P/overflow
// - Live counter readable as two bytes
// - P period is value times 256 in PWM, value plus one times 256 otherwise, zero full
// - Clear on A raises only the A flag
module stm_timer
  import stm_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic hs_tick,
  input wire logic sub_tick,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic timer_out_pin,
  output logic match_a_flag,
  output logic match_p_flag,
  output logic timer_irq
);
  import stm_pkg::*;

  logic [7:0] ctrl0, next_ctrl0;
  logic [7:0] ctrl1, next_ctrl1;
  logic [15:0] cmp_a, next_cmp_a;
  logic [7:0] cmp_p, next_cmp_p;
  logic [7:0] rdata, next_rdata;
  logic [15:0] count, next_count;
  logic [7:0] div_sys, next_div_sys;
  logic [7:0] div_hs, next_div_hs;
  logic run_q, next_run_q;
  logic pin_lvl, next_pin_lvl;
  logic flag_a, next_flag_a;
  logic flag_p, next_flag_p;
  logic out_q, next_out_q;

  logic count_hold, counter_run, run_rise, tick;
  logic pin_initial_level, pin_invert, duty_period_swap, clear_source_sel;
  logic [1:0] pin_action_sel;
  stm_mode_t op_mode_sel;
  stm_src_t tick_source_sel;
  logic match_a, match_p, overflow, pwm_mode;
  logic [15:0] period_val, duty_val;
  logic pwm_active;

  assign count_hold = ctrl0[CTRL0_HOLD];
  assign counter_run = ctrl0[CTRL0_RUN];
  assign tick_source_sel = stm_src_t'(ctrl0[CTRL0_SRC_LSB +: 3]);
  assign op_mode_sel = stm_mode_t'(ctrl1[CTRL1_MODE_LSB +: 2]);
  assign pin_action_sel = ctrl1[CTRL1_ACT_LSB +: 2];
  assign pin_initial_level = ctrl1[CTRL1_INIT];
  assign pin_invert = ctrl1[CTRL1_INV];
  assign duty_period_swap = ctrl1[CTRL1_SWAP];
  assign clear_source_sel = ctrl1[CTRL1_CLRSEL];
  assign run_rise = counter_run && !run_q;
  assign pwm_mode = (op_mode_sel == STM_MODE_PWM);

  // Clock dividers free-run so tick phase does not depend on run
  always_comb
  begin
    next_div_sys = (div_sys == SYS_DIV - 8'h01) ? 8'h00 : div_sys + 8'h01;
    next_div_hs = div_hs;
    if (hs_tick)
    begin
      next_div_hs = (div_hs == HS_DIV64 - 8'h01) ? 8'h00 : div_hs + 8'h01;
    end
  end

  always_comb
  begin
    unique case (tick_source_sel)
      STM_SRC_SYS4: tick = (div_sys == 8'h00);
      STM_SRC_SYS: tick = 1'b1;
      STM_SRC_HS16: tick = hs_tick
        && ((div_hs & (HS_DIV16 - 8'h01)) == 8'h00);
      STM_SRC_HS64: tick = hs_tick && (div_hs == 8'h00);
      STM_SRC_SUB0, STM_SRC_SUB1: tick = sub_tick;
      // Reserved codes stop the counter rather than pick a random clock
      default: tick = 1'b0;
    endcase
  end

  assign match_a = (count == cmp_a);
  assign match_p = (count[15:8] == cmp_p);
  assign overflow = (count == CNT_MAX);

  // PWM: P side is value times 256, zero as period means full 65536 span
  always_comb
  begin
    if (duty_period_swap)
    begin
      period_val = cmp_a;
      duty_val = {cmp_p, 8'h00};
    end
    else
    begin
      period_val = {cmp_p, 8'h00};
      duty_val = cmp_a;
    end
  end
  assign pwm_active = (duty_val == 16'h0000) ? 1'b0 :
    ((period_val != 16'h0000) && (duty_val >= period_val)) ? 1'b1 :
    (count < duty_val);

  // Counter, flags and pin level
  always_comb
  begin
    logic clr, ev_a, ev_p, at_end;
    clr = 1'b0;
    ev_a = 1'b0;
    ev_p = 1'b0;
    at_end = 1'b0;
    next_count = count;
    next_run_q = counter_run;
    next_pin_lvl = pin_lvl;
    next_flag_a = flag_a;
    next_flag_p = flag_p;
    if (run_rise)
    begin
      next_count = 16'h0000;
      next_pin_lvl = pin_initial_level;
    end
    else if (counter_run && !count_hold && tick)
    begin
      if (pwm_mode)
      begin
        ev_a = match_a;
        ev_p = match_p && (count[7:0] == 8'hFF);
        // Period end: 16-bit register match, or 256-multiple, or wrap
        if (duty_period_swap)
        begin
          at_end = (period_val == 16'h0000) ? overflow :
            (count == period_val - 16'h0001);
        end
        else
        begin
          at_end = (cmp_p == 8'h00) ? overflow :
            (count == {cmp_p, 8'h00} - 16'h0001);
        end
        clr = at_end;
      end
      else if (clear_source_sel)
      begin
        ev_a = match_a && (cmp_a != 16'h0000);
        ev_p = 1'b0;
        clr = ev_a || overflow;
      end
      else
      begin
        ev_a = match_a && (cmp_a != 16'h0000);
        ev_p = (cmp_p == 8'h00) ? overflow :
          (match_p && (count[7:0] == 8'hFF));
        clr = ev_p;
      end
      next_count = clr ? 16'h0000 : count + 16'h0001;
      if (ev_a && (op_mode_sel == STM_MODE_COMPARE))
      begin
        unique case (pin_action_sel)
          2'h0: next_pin_lvl = pin_lvl;
          2'h1: next_pin_lvl = 1'b0;
          2'h2: next_pin_lvl = 1'b1;
          2'h3: next_pin_lvl = !pin_lvl;
        endcase
      end
    end
    // Hardware set wins over a software clear in the same cycle
    if (reg_write && reg_addr == REG_CTRL1)
    begin
      next_flag_a = 1'b0;
      next_flag_p = 1'b0;
    end
    if (ev_a)
    begin
      next_flag_a = 1'b1;
    end
    if (ev_p)
    begin
      next_flag_p = 1'b1;
    end
  end

  // Pin output per mode
  always_comb
  begin
    logic lvl;
    lvl = 1'b0;
    unique case (op_mode_sel)
      STM_MODE_COMPARE: lvl = pin_lvl;
      STM_MODE_PWM:
      begin
        unique case (pin_action_sel)
          2'h0: lvl = !pin_initial_level;
          2'h1: lvl = pin_initial_level;
          2'h2: lvl = pwm_active ? pin_initial_level : !pin_initial_level;
          2'h3: lvl = pin_lvl;
        endcase
      end
      // Undefined or timer mode: pin not used, level low before invert
      STM_MODE_UNDEF, STM_MODE_TIMER: lvl = 1'b0;
    endcase
    // Invert has no effect in timer mode
    next_out_q = (op_mode_sel == STM_MODE_TIMER) ? lvl :
      lvl ^ pin_invert;
  end

  // Register port
  always_comb
  begin
    next_ctrl0 = ctrl0;
    next_ctrl1 = ctrl1;
    next_cmp_a = cmp_a;
    next_cmp_p = cmp_p;
    next_rdata = 8'h00;
    if (reg_write)
    begin
      unique case (reg_addr)
        REG_CTRL0: next_ctrl0 = reg_wdata & CTRL0_WMASK;
        REG_CTRL1: next_ctrl1 = reg_wdata;
        REG_CMPA_LO: next_cmp_a[7:0] = reg_wdata;
        REG_CMPA_HI: next_cmp_a[15:8] = reg_wdata;
        REG_CMPP: next_cmp_p = reg_wdata;
        default: next_ctrl0 = ctrl0;
      endcase
    end
    if (reg_read)
    begin
      unique case (reg_addr)
        REG_CTRL0: next_rdata = ctrl0 & CTRL0_WMASK;
        REG_CTRL1: next_rdata = ctrl1;
        REG_CNT_LO: next_rdata = count[7:0];
        REG_CNT_HI: next_rdata = count[15:8];
        REG_CMPA_LO: next_rdata = cmp_a[7:0];
        REG_CMPA_HI: next_rdata = cmp_a[15:8];
        REG_CMPP: next_rdata = cmp_p;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ctrl0 <= CTRL0_RESET;
      ctrl1 <= CTRL1_RESET;
      cmp_a <= {CMP_RESET, CMP_RESET};
      cmp_p <= CMP_RESET;
      rdata <= 8'h00;
      count <= 16'h0000;
      div_sys <= 8'h00;
      div_hs <= 8'h00;
      run_q <= 1'b0;
      pin_lvl <= 1'b0;
      flag_a <= 1'b0;
      flag_p <= 1'b0;
      out_q <= 1'b0;
    end
    else
    begin
      ctrl0 <= next_ctrl0;
      ctrl1 <= next_ctrl1;
      cmp_a <= next_cmp_a;
      cmp_p <= next_cmp_p;
      rdata <= next_rdata;
      count <= next_count;
      div_sys <= next_div_sys;
      div_hs <= next_div_hs;
      run_q <= next_run_q;
      pin_lvl <= next_pin_lvl;
      flag_a <= next_flag_a;
      flag_p <= next_flag_p;
      out_q <= next_out_q;
    end
  end

  assign reg_rdata = rdata;
  assign timer_out_pin = out_q;
  assign match_a_flag = flag_a;
  assign match_p_flag = flag_p;
  assign timer_irq = flag_a || flag_p;

  a_run_clears: assert property (@(posedge clock) disable iff (srst)
    (counter_run && !run_q) |=> (count == 16'h0000))
    else $error("run rise did not clear counter");
  a_hold_freezes: assert property (@(posedge clock) disable iff (srst)
    (count_hold && !run_rise) |=> (count == $past(count)))
    else $error("counter moved while held");
  a_off_keeps: assert property (@(posedge clock) disable iff (srst)
    (!counter_run && !$past(counter_run)) |-> $stable(count))
    else $error("counter moved while off");
  a_no_p_flag: assert property (@(posedge clock) disable iff (srst)
    (!pwm_mode && clear_source_sel && !flag_p) |=> !flag_p)
    else $error("P flag raised with A clear");
  a_ctrl0_low_zero: assert property (@(posedge clock)
    disable iff (srst)
    $past(reg_read) && $past(reg_addr) == REG_CTRL0 |-> rdata[2:0] == 3'h0)
    else $error("control zero low bits not zero");
  a_cnt_read: assert property (@(posedge clock) disable iff (srst)
    (reg_read && reg_addr == REG_CNT_LO) |=> rdata == $past(count[7:0]))
    else $error("counter low byte wrong");
  a_pin_init: assert property (@(posedge clock) disable iff (srst)
    run_rise |=> pin_lvl == $past(pin_initial_level))
    else $error("pin not reset to initial level");
  a_a_match_flag: assert property (@(posedge clock) disable iff (srst)
    (counter_run && !run_rise && !count_hold && tick && match_a
     && cmp_a != 16'h0000 && op_mode_sel != STM_MODE_PWM) |=> flag_a)
    else $error("A match did not set flag");
  a_src_reserved: assert property (@(posedge clock) disable iff (srst)
    (tick_source_sel == STM_SRC_RSV0 && !run_rise) |=> $stable(count))
    else $error("reserved source counted");
  // Plain tick with no match or wrap pending must add one
  a_count_step: assert property (@(posedge clock) disable iff (srst)
    (counter_run && !run_rise && !count_hold && tick && !pwm_mode
     && !match_a && !match_p && !overflow)
    |=> count == $past(count) + 16'h0001)
    else $error("counter did not advance on tick");
  a_a_clears: assert property (@(posedge clock) disable iff (srst)
    (counter_run && !run_rise && !count_hold && tick && !pwm_mode
     && clear_source_sel && match_a && cmp_a != 16'h0000)
    |=> count == 16'h0000)
    else $error("A match did not clear counter");
  a_p_clears: assert property (@(posedge clock) disable iff (srst)
    (counter_run && !run_rise && !count_hold && tick && !pwm_mode
     && !clear_source_sel && cmp_p != 8'h00 && count == {cmp_p, 8'hFF})
    |=> (count == 16'h0000 && flag_p))
    else $error("P match did not clear counter");
  a_swap_period: assert property (@(posedge clock) disable iff (srst)
    (counter_run && !run_rise && !count_hold && tick && pwm_mode
     && duty_period_swap && cmp_a != 16'h0000
     && count == cmp_a - 16'h0001) |=> count == 16'h0000)
    else $error("A did not set the PWM period");
  // PWM excluded: a one-count period may legally sit at zero
  a_sys_tick: assert property (@(posedge clock) disable iff (srst)
    (tick_source_sel == STM_SRC_SYS && counter_run && !count_hold
     && !run_rise && !pwm_mode) |=> count != $past(count))
    else $error("system clock source did not count");
  a_pwm_inactive: assert property (@(posedge clock) disable iff (srst)
    (pwm_mode && pin_action_sel == 2'h0)
    |=> timer_out_pin == $past(!pin_initial_level ^ pin_invert))
    else $error("PWM inactive level wrong");
  a_pwm_active: assert property (@(posedge clock) disable iff (srst)
    (pwm_mode && pin_action_sel == 2'h1)
    |=> timer_out_pin == $past(pin_initial_level ^ pin_invert))
    else $error("PWM active level wrong");
  a_rdata_idle: assert property (@(posedge clock) disable iff (srst)
    !reg_read |=> rdata == 8'h00)
    else $error("read data not zero when idle");
endmodule : stm_timer
`default_nettype wire

// ==== test_stm_timer.sv ====
/*
 Self-checking bench for stm_timer: registers, counting, tick sources,
 compare and PWM pin behaviour.
 Assumes the 0..6 byte map and one-cycle read latency of the design.
*/
`timescale 1ns/1ps
`default_nettype none
module test_stm_timer;
  import stm_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic hs_tick = 1'b0;
  logic sub_tick = 1'b0;
  logic [1:0] phase = 2'h0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic timer_out_pin;
  logic match_a_flag;
  logic match_p_flag;
  logic timer_irq;
  logic [7:0] v0;
  logic [7:0] v1;
  int n_errors = 0;
  int checks = 0;
  int gaps [8] = '{40, 40, 64, 128, 40, 40, 40, 40};
  logic [7:0] exps [8] = '{8'h0A, 8'h28, 8'h02, 8'h01,
    8'h0A, 8'h0A, 8'h00, 8'h00};
  stm_timer u_dut (
    .clock(clock),
    .srst(srst),
    .hs_tick(hs_tick),
    .sub_tick(sub_tick),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .timer_out_pin(timer_out_pin),
    .match_a_flag(match_a_flag),
    .match_p_flag(match_p_flag),
    .timer_irq(timer_irq)
  );
  always #50 clock = ~clock;
  // Fast clock enables so divided rates show in few cycles
  always @(posedge clock)
  begin
    phase <= phase + 2'h1;
    hs_tick <= ~hs_tick;
    sub_tick <= (phase == 2'h3);
  end
  task results;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task idle(input int n);
    repeat (n) @(posedge clock);
  endtask : idle
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task rdc(input string nm, input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(nm, e, d);
  endtask : rdc
  task pin_is(input logic e);
    // Step off the edge so the registered pin has settled
    #1;
    chk("pin", {7'h00, e}, {7'h00, timer_out_pin});
  endtask : pin_is
  // Stop first: mode and pin action change only while off
  task restart(input logic [7:0] c1);
    wr(3'h0, 8'h00);
    wr(3'h1, c1);
    wr(3'h0, 8'h18);
    idle(3);
  endtask : restart
  task rate(input logic [2:0] s, input int gap, input logic [7:0] e);
    logic [7:0] a;
    logic [7:0] b;
    wr(3'h0, {1'b0, s, 4'h8});
    idle(200);
    rd(3'h2, a);
    idle(gap - 2);
    rd(3'h2, b);
    chk("tick rate", e, b - a);
  endtask : rate
  task wait_pin(input logic e, input int lim);
    int i;
    i = 0;
    #1;
    while (timer_out_pin !== e && i < lim)
    begin
      @(posedge clock);
      #1;
      i++;
    end
    pin_is(e);
    if (timer_out_pin !== e)
      results();
  endtask : wait_pin
  // Window is two periods, so phase does not matter
  task high_count(input logic [7:0] e);
    int n;
    n = 0;
    repeat (512)
    begin
      @(posedge clock);
      #1;
      if (timer_out_pin === 1'b1)
        n++;
    end
    chk("pwm high", e, n[9:2]);
  endtask : high_count
  initial
  begin
    idle(3);
    srst <= 1'b0;
    for (int i = 0; i < 8; i++)
      rdc("reset value", i[2:0], 8'h00);
    wr(3'h0, 8'hF7);
    rdc("ctrl0", 3'h0, 8'hF0);
    wr(3'h4, 8'h5A);
    wr(3'h5, 8'hA5);
    wr(3'h6, 8'h3C);
    wr(3'h1, 8'hC3);
    rdc("cmpa lo", 3'h4, 8'h5A);
    rdc("cmpa hi", 3'h5, 8'hA5);
    rdc("cmpp", 3'h6, 8'h3C);
    rdc("ctrl1", 3'h1, 8'hC3);
    wr(3'h2, 8'hFF);
    rdc("count lo", 3'h2, 8'h00);
    wr(3'h0, 8'h18);
    idle(50);
    wr(3'h0, 8'h10);
    rd(3'h2, v0);
    idle(20);
    rdc("count off", 3'h2, v0);
    wr(3'h0, 8'h98);
    idle(10);
    rdc("count lo", 3'h2, 8'h00);
    rdc("count hi", 3'h3, 8'h00);
    wr(3'h0, 8'h18);
    rd(3'h2, v0);
    rd(3'h2, v1);
    chk("count step", 8'h02, v1 - v0);
    wr(3'h0, 8'h98);
    rd(3'h2, v0);
    idle(10);
    rdc("count held", 3'h2, v0);
    wr(3'h1, 8'hC0);
    wr(3'h6, 8'h00);
    for (int i = 0; i < 8; i++)
      rate(i[2:0], gaps[i], exps[i]);
    wr(3'h6, 8'h01);
    wr(3'h5, 8'h00);
    wr(3'h4, 8'h00);
    restart(8'h00);
    idle(600);
    rdc("count hi", 3'h3, 8'h00);
    chk("p flag", 8'h01, {7'h00, match_p_flag});
    chk("irq", 8'h01, {7'h00, timer_irq});
    wr(3'h5, 8'h01);
    wr(3'h4, 8'h80);
    restart(8'h31);
    pin_is(1'b0);
    wait_pin(1'b1, 400);
    wait_pin(1'b0, 400);
    chk("a flag", 8'h01, {7'h00, match_a_flag});
    chk("p flag", 8'h00, {7'h00, match_p_flag});
    restart(8'h11);
    idle(800);
    pin_is(1'b0);
    restart(8'h29);
    idle(800);
    pin_is(1'b1);
    restart(8'h19);
    pin_is(1'b1);
    wait_pin(1'b0, 400);
    restart(8'h0D);
    pin_is(1'b0);
    restart(8'hCC);
    pin_is(1'b0);
    restart(8'h40);
    pin_is(1'b0);
    for (int i = 0; i < 4; i++)
    begin
      restart({3'h4, i[0], i[1], 3'h0});
      pin_is(i[0] ? i[1] : ~i[1]);
    end
    // Single pulse: pin holds the level set at the enable edge
    restart(8'hB8);
    pin_is(1'b1);
    restart(8'hB0);
    pin_is(1'b0);
    wr(3'h5, 8'h00);
    wr(3'h4, 8'h40);
    restart(8'hA8);
    idle(300);
    high_count(8'h20);
    wr(3'h6, 8'h02);
    wr(3'h5, 8'h01);
    wr(3'h4, 8'h00);
    restart(8'hAA);
    idle(300);
    high_count(8'h80);
    results();
  end
endmodule : test_stm_timer
`default_nettype wire
